//--- common/supply_monitor_pkg.sv
// Shared constants and types for the supply monitor control block.
// Assumes a 50 MHz system clock and a word-aligned register bus.
package supply_monitor_pkg;

  // ****************************************
  // Register indices and byte addresses
  // ****************************************
  localparam logic [3:0] IDX_MODE_CTRL = 4'h0;
  localparam logic [3:0] IDX_THRESHOLD = 4'h1;
  localparam logic [3:0] IDX_WARN_LEVEL = 4'h8;
  localparam logic [3:0] IDX_WARN_IRQ_CTRL = 4'h9;
  localparam logic [3:0] IDX_WARN_FLAGS = 4'hA;
  localparam logic [3:0] IDX_WARN_STATUS = 4'hB;
  localparam int ADDR_IDX_LSB = 2;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int SAMPLE_RATE_BIT = 4;
  localparam int ACTIVE_MODE_LSB = 2;
  localparam int SLEEP_MODE_LSB = 0;
  localparam int TRIGGER_SEL_LSB = 1;
  localparam int IRQ_ENABLE_BIT = 0;
  localparam int IRQ_FLAG_BIT = 0;
  localparam int WARN_STATE_BIT = 0;

  // ****************************************
  // Reset values and codes
  // ****************************************
  localparam logic [1:0] WARN_LEVEL_RESET = 2'h0;
  localparam logic [1:0] TRIGGER_RESET = 2'h0;
  localparam logic [2:0] THRESHOLD_LOW_CODE = 3'h2;
  localparam logic [2:0] THRESHOLD_HIGH_CODE = 3'h7;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLOCK_HZ = 50000000;
  localparam int SAMPLE_FAST_HZ = 1000;
  localparam int SAMPLE_SLOW_HZ = 125;
  localparam int SAMPLE_FAST_CYCLES = CLOCK_HZ / SAMPLE_FAST_HZ;
  localparam int SAMPLE_SLOW_CYCLES = CLOCK_HZ / SAMPLE_SLOW_HZ;

  // Monitor operating modes.
  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_CONTINUOUS = 2'b01,
    MODE_SAMPLED = 2'b10,
    MODE_CONT_HOLD = 2'b11
  } monitor_mode_t;

  // Warning trigger conditions.
  typedef enum logic [1:0] {
    TRIG_BELOW = 2'b00,
    TRIG_ABOVE = 2'b01,
    TRIG_EITHER = 2'b10,
    TRIG_RESERVED = 2'b11
  } trigger_sel_t;

  // Configuration loaded from fuses at reset.
  typedef struct packed {
    logic sampleRateSel;
    logic [1:0] activeMode;
    logic [1:0] sleepMode;
    logic [2:0] thresholdCode;
  } monitor_fuse_config_t;

endpackage

//--- verilog/warning_detector.sv
// Samples the early-warning comparator and reports level changes.
// Assumes the comparator output is synchronous to ref_clk.
`timescale 1ns/100ps
module warning_detector #(
  parameter int FAST_CYCLES = supply_monitor_pkg::SAMPLE_FAST_CYCLES,
  parameter int SLOW_CYCLES = supply_monitor_pkg::SAMPLE_SLOW_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Control
  input wire logic enable,
  input wire logic sampled,
  input wire logic slowRate,
  // Comparator and results
  input wire logic belowWarning,
  output logic level_ff,
  output logic fallEvent_ff,
  output logic riseEvent_ff
);

  logic [31:0] tick_ff;
  logic valid_ff;
  logic sampleNow;
  logic [31:0] period;

  // Continuous mode samples every cycle; sampled mode once a period.
  assign period = slowRate ? 32'(SLOW_CYCLES) : 32'(FAST_CYCLES);
  assign sampleNow = enable && (!sampled || tick_ff == 32'h0);

  // Sample period counter.
  always_ff @(posedge ref_clk) begin
    if (rst || !enable || !sampled || tick_ff == 32'h0) begin
      tick_ff <= period - 32'h1;
    end else begin
      tick_ff <= tick_ff - 32'h1;
    end
  end

  // Level capture; the first sample after enable loads without an event.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      level_ff <= 1'b0;
      valid_ff <= 1'b0;
      fallEvent_ff <= 1'b0;
      riseEvent_ff <= 1'b0;
    end else begin
      fallEvent_ff <= sampleNow && valid_ff && belowWarning && !level_ff;
      riseEvent_ff <= sampleNow && valid_ff && !belowWarning && level_ff;
      if (!enable) begin
        valid_ff <= 1'b0;
      end else if (sampleNow) begin
        level_ff <= belowWarning;
        valid_ff <= 1'b1;
      end
    end
  end

endmodule // warning_detector

//--- verilog/ahb_reg_slave.sv
// AHB-Lite slave front end for a bank of byte-wide registers.
// Assumes single word transfers; reads take one wait state.
`timescale 1ns/100ps
module ahb_reg_slave (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // AHB-Lite
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata_ff,
  output logic hreadyout_ff,
  // Register side
  output logic wrPulse,
  output logic [3:0] regIdx_ff,
  output logic [7:0] wrData,
  input wire logic [7:0] rdValue
);

  logic wrPend_ff;
  logic rdPend_ff;
  logic take;

  // An address phase is taken on NONSEQ or SEQ with hready high.
  assign take = hsel && hready && htrans[1];
  assign wrPulse = wrPend_ff;
  assign wrData = hwdata[7:0];

  // Address phase capture and data phase sequencing.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wrPend_ff <= 1'b0;
      rdPend_ff <= 1'b0;
      regIdx_ff <= 4'h0;
      hreadyout_ff <= 1'b1;
      hrdata_ff <= 32'h0;
    end else begin
      wrPend_ff <= take && hwrite;
      rdPend_ff <= take && !hwrite;
      if (take) begin
        regIdx_ff <= haddr[supply_monitor_pkg::ADDR_IDX_LSB +: 4];
      end
      // The wait state lets a write just before this read land first.
      hreadyout_ff <= !(take && !hwrite);
      if (rdPend_ff) begin
        hrdata_ff <= {24'h0, rdValue};
      end
    end
  end

endmodule // ahb_reg_slave

//--- verilog/supply_monitor_control.sv
// Control and status registers of the supply monitor.
// Assumes fuse values, sleep state and comparator outputs are
// synchronous to ref_clk, and that the processor's unlock logic
// raises timedUnlock while a protected write is permitted.
//
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/100ps
module supply_monitor_control #(
  parameter int FAST_CYCLES = supply_monitor_pkg::SAMPLE_FAST_CYCLES,
  parameter int SLOW_CYCLES = supply_monitor_pkg::SAMPLE_SLOW_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // AHB-Lite register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp_ff,
  // Fuse configuration and processor state
  input wire supply_monitor_pkg::monitor_fuse_config_t fuseConfig,
  input wire logic timedUnlock,
  input wire logic sleepDeep,
  // Analog comparators
  input wire logic monitorRunning,
  input wire logic belowWarning,
  output supply_monitor_pkg::monitor_mode_t monitorMode_ff,
  output logic sampleRateSel_ff,
  output logic [2:0] thresholdCode_ff,
  output logic [1:0] warningLevelSel_ff,
  // Processor side
  output logic holdExecution_ff,
  output logic warningIrq_ff
);

  // ****************************************
  // Declarations
  // ****************************************
  supply_monitor_pkg::monitor_mode_t activeMode_ff;
  supply_monitor_pkg::monitor_mode_t sleepMode_ff;
  supply_monitor_pkg::monitor_mode_t nxt_monitorMode;
  supply_monitor_pkg::trigger_sel_t warningTriggerSel_ff;
  logic warningIrqEnable_ff;
  logic warningIrqFlag_ff;
  logic warningState_ff;
  logic sleepDeep_ff;
  logic wrPulse;
  logic [3:0] regIdx;
  logic [7:0] wrData;
  logic [7:0] rdValue;
  logic monitorOn;
  logic detLevel;
  logic detFall;
  logic detRise;
  logic trigger;

  // Write strobe qualified by register index.
  function automatic logic wrHit(input logic [3:0] idx, input logic [3:0] want,
                                 input logic strobe);
    wrHit = strobe && idx == want;
  endfunction

  // ****************************************
  // Bus front end
  // ****************************************

  // Register bus slave; only word transfers are expected, so hsize
  // is not decoded.
  ahb_reg_slave u_bus (
    .ref_clk(ref_clk),
    .rst(rst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .hwdata(hwdata),
    .hrdata_ff(hrdata),
    .hreadyout_ff(hreadyout),
    .wrPulse(wrPulse),
    .regIdx_ff(regIdx),
    .wrData(wrData),
    .rdValue(rdValue)
  );

  // The slave always answers OKAY.
  always_ff @(posedge ref_clk) begin
    hresp_ff <= 1'b0;
  end

  // ****************************************
  // Mode control register
  // ****************************************

  // Fuse values are taken while reset is held; the active mode and
  // threshold never change afterwards.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      activeMode_ff <= supply_monitor_pkg::monitor_mode_t'(fuseConfig.activeMode);
      thresholdCode_ff <= fuseConfig.thresholdCode;
    end
  end

  // Sample rate bit is written freely, without the unlock.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sampleRateSel_ff <= fuseConfig.sampleRateSel;
    end else if (wrHit(regIdx, supply_monitor_pkg::IDX_MODE_CTRL, wrPulse)) begin
      sampleRateSel_ff <= wrData[supply_monitor_pkg::SAMPLE_RATE_BIT];
    end
  end

  // Sleep mode changes only inside the unlock window and never to
  // the reserved code.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sleepMode_ff <= supply_monitor_pkg::monitor_mode_t'(fuseConfig.sleepMode);
    end else if (wrHit(regIdx, supply_monitor_pkg::IDX_MODE_CTRL, wrPulse) && timedUnlock
                 && wrData[supply_monitor_pkg::SLEEP_MODE_LSB +: 2] != 2'h3) begin
      sleepMode_ff <= supply_monitor_pkg::monitor_mode_t'(
        wrData[supply_monitor_pkg::SLEEP_MODE_LSB +: 2]);
    end
  end

  // ****************************************
  // Operating mode selection
  // ****************************************

  // Standby and power-down use the sleep mode, otherwise the active mode.
  always_comb begin
    nxt_monitorMode = sleepDeep ? sleepMode_ff : activeMode_ff;
  end

  assign monitorOn = monitorMode_ff != supply_monitor_pkg::MODE_OFF;

  // Mode driven to the analog monitor.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      monitorMode_ff <= supply_monitor_pkg::MODE_OFF;
      sleepDeep_ff <= 1'b0;
    end else begin
      monitorMode_ff <= nxt_monitorMode;
      sleepDeep_ff <= sleepDeep;
    end
  end

  // With active mode MODE_CONT_HOLD, execution is held from wake until the monitor reports it runs.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      holdExecution_ff <= 1'b0;
    end else if (sleepDeep_ff && !sleepDeep
                 && activeMode_ff == supply_monitor_pkg::MODE_CONT_HOLD) begin
      holdExecution_ff <= 1'b1;
    end else if (monitorRunning) begin
      holdExecution_ff <= 1'b0;
    end
  end

  // ****************************************
  // Early warning control registers
  // ****************************************

  // Warning level select; reserved codes are stored as written.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      warningLevelSel_ff <= supply_monitor_pkg::WARN_LEVEL_RESET;
    end else if (wrHit(regIdx, supply_monitor_pkg::IDX_WARN_LEVEL, wrPulse)) begin
      warningLevelSel_ff <= wrData[1:0];
    end
  end

  // Interrupt control: trigger selection and enable.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      warningTriggerSel_ff <= supply_monitor_pkg::trigger_sel_t'(
        supply_monitor_pkg::TRIGGER_RESET);
      warningIrqEnable_ff <= 1'b0;
    end else if (wrHit(regIdx, supply_monitor_pkg::IDX_WARN_IRQ_CTRL, wrPulse)) begin
      warningTriggerSel_ff <= supply_monitor_pkg::trigger_sel_t'(
        wrData[supply_monitor_pkg::TRIGGER_SEL_LSB +: 2]);
      warningIrqEnable_ff <= wrData[supply_monitor_pkg::IRQ_ENABLE_BIT];
    end
  end

  // ****************************************
  // Warning detection
  // ****************************************

  // The detector runs only while the monitor mode is not MODE_OFF, in the same mode.
  warning_detector #(
    .FAST_CYCLES(FAST_CYCLES),
    .SLOW_CYCLES(SLOW_CYCLES)
  ) u_detect (
    .ref_clk(ref_clk),
    .rst(rst),
    .enable(monitorOn),
    .sampled(monitorMode_ff == supply_monitor_pkg::MODE_SAMPLED),
    .slowRate(sampleRateSel_ff),
    .belowWarning(belowWarning),
    .level_ff(detLevel),
    .fallEvent_ff(detFall),
    .riseEvent_ff(detRise)
  );

  // Trigger matching the configured condition; reserved code never fires.
  always_comb begin
    unique case (warningTriggerSel_ff)
      supply_monitor_pkg::TRIG_BELOW: trigger = detFall;
      supply_monitor_pkg::TRIG_ABOVE: trigger = detRise;
      supply_monitor_pkg::TRIG_EITHER: trigger = detFall || detRise;
      supply_monitor_pkg::TRIG_RESERVED: trigger = 1'b0;
    endcase
  end

  // Live status, held while the monitor is off.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      warningState_ff <= 1'b0;
    end else if (monitorOn) begin
      warningState_ff <= detLevel;
    end
  end

  // ****************************************
  // Interrupt flag and request
  // ****************************************

  // Sticky flag; a trigger in the clearing cycle wins over the clear.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      warningIrqFlag_ff <= 1'b0;
    end else if (trigger && monitorOn) begin
      warningIrqFlag_ff <= 1'b1;
    end else if (wrHit(regIdx, supply_monitor_pkg::IDX_WARN_FLAGS, wrPulse)
                 && wrData[supply_monitor_pkg::IRQ_FLAG_BIT]) begin
      warningIrqFlag_ff <= 1'b0;
    end
  end

  // Level request while enabled and flagged.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      warningIrq_ff <= 1'b0;
    end else begin
      warningIrq_ff <= warningIrqEnable_ff && warningIrqFlag_ff;
    end
  end

  // ****************************************
  // Read back
  // ****************************************

  // Read mux; unmapped indices and unused bits read zero.
  always_comb begin
    rdValue = 8'h00;
    unique case (regIdx)
      supply_monitor_pkg::IDX_MODE_CTRL: begin
        rdValue[supply_monitor_pkg::SAMPLE_RATE_BIT] = sampleRateSel_ff;
        rdValue[supply_monitor_pkg::ACTIVE_MODE_LSB +: 2] = activeMode_ff;
        rdValue[supply_monitor_pkg::SLEEP_MODE_LSB +: 2] = sleepMode_ff;
      end
      supply_monitor_pkg::IDX_THRESHOLD: begin
        rdValue[2:0] = thresholdCode_ff;
      end
      supply_monitor_pkg::IDX_WARN_LEVEL: begin
        rdValue[1:0] = warningLevelSel_ff;
      end
      supply_monitor_pkg::IDX_WARN_IRQ_CTRL: begin
        rdValue[supply_monitor_pkg::TRIGGER_SEL_LSB +: 2] = warningTriggerSel_ff;
        rdValue[supply_monitor_pkg::IRQ_ENABLE_BIT] = warningIrqEnable_ff;
      end
      supply_monitor_pkg::IDX_WARN_FLAGS: begin
        rdValue[supply_monitor_pkg::IRQ_FLAG_BIT] = warningIrqFlag_ff;
      end
      supply_monitor_pkg::IDX_WARN_STATUS: begin
        rdValue[supply_monitor_pkg::WARN_STATE_BIT] = warningState_ff;
      end
      default: begin
        rdValue = 8'h00;
      end
    endcase
  end

endmodule // supply_monitor_control

//--- tb/smc_monitor.sv
// Checker for the supply monitor control block, watching its ports only.
// Assumes it is bound into the block and connected by port name.
`timescale 1ns/100ps
module smc_monitor (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  // Fuses, sleep state and comparators
  input wire supply_monitor_pkg::monitor_fuse_config_t fuseConfig,
  input wire logic sleepDeep,
  input wire logic monitorRunning,
  // Monitor outputs
  input wire supply_monitor_pkg::monitor_mode_t monitorMode_ff,
  input wire logic sampleRateSel_ff,
  input wire logic [2:0] thresholdCode_ff,
  input wire logic holdExecution_ff,
  input wire logic warningIrq_ff
);
  logic [1:0] activeCap_ff;
  logic wrPend_ff;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Keeps the fused active mode and marks the data phase of each write.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      activeCap_ff <= fuseConfig.activeMode;
    end
    wrPend_ff <= hsel && hready && htrans[1] && hwrite;
  end
  // ****************************************
  // Assertions
  // ****************************************
  property p_load;
    disable iff (1'b0) rst |=> {sampleRateSel_ff, thresholdCode_ff} ==
      {$past(fuseConfig.sampleRateSel), $past(fuseConfig.thresholdCode)};
  endproperty
  a_load: assert property (p_load)
    else $error("fuse values not loaded in reset");
  property p_roStable;
    !$past(rst) |-> $stable(thresholdCode_ff);
  endproperty
  a_roStable: assert property (p_roStable)
    else $error("read-only field changed");
  property p_activeMode;
    !$past(rst) && !$past(sleepDeep) |-> monitorMode_ff == activeCap_ff;
  endproperty
  a_activeMode: assert property (p_activeMode)
    else $error("awake mode differs from fused mode");
  property p_holdEnd;
    holdExecution_ff && monitorRunning |=> !holdExecution_ff;
  endproperty
  a_holdEnd: assert property (p_holdEnd)
    else $error("hold kept after monitor runs");
  property p_holdOnly;
    activeCap_ff != supply_monitor_pkg::MODE_CONT_HOLD |-> !holdExecution_ff;
  endproperty
  a_holdOnly: assert property (p_holdOnly)
    else $error("hold without hold mode");
  property p_upperZero;
    hreadyout |-> hrdata[31:8] == 24'h0;
  endproperty
  a_upperZero: assert property (p_upperZero)
    else $error("unimplemented read bits set");
  property p_readWait;
    hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_readWait: assert property (p_readWait)
    else $error("read wait state wrong");
  property p_writeReady;
    hsel && hready && htrans[1] && hwrite |=> hreadyout;
  endproperty
  a_writeReady: assert property (p_writeReady)
    else $error("write stalled");
  property p_irqHold;
    warningIrq_ff && !wrPend_ff && !$past(wrPend_ff) |=> warningIrq_ff;
  endproperty
  a_irqHold: assert property (p_irqHold)
    else $error("interrupt dropped without a write");
endmodule // smc_monitor

//--- tb/analog_partner.sv
// Model of the analog comparators and the fuse loader.
// Assumes the bench steers the supply level, fuse word and start delay.
`timescale 1ns/100ps
module analog_partner (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Bench control
  input wire logic supplyLow,
  input wire logic [7:0] fuseWord,
  input wire logic [3:0] runDelay,
  input wire logic sleepDeep,
  // Toward the block
  output supply_monitor_pkg::monitor_fuse_config_t fuseConfig,
  output logic monitorRunning,
  output logic belowWarning
);
  logic [3:0] wakeCnt_ff;
  logic run_ff;
  logic below_ff;
  // The fuse loader presents the stored word all the time.
  assign fuseConfig = fuseWord;
  assign monitorRunning = run_ff;
  assign belowWarning = below_ff;
  // The comparator follows the supply one cycle late.
  always_ff @(posedge ref_clk) begin
    below_ff <= supplyLow;
  end
  // The monitor restarts after sleep and runs after runDelay + 1 cycles.
  always_ff @(posedge ref_clk) begin
    if (rst || sleepDeep) begin
      wakeCnt_ff <= 4'h0;
      run_ff <= 1'b0;
    end else if (wakeCnt_ff < runDelay) begin
      wakeCnt_ff <= wakeCnt_ff + 4'h1;
    end else begin
      run_ff <= 1'b1;
    end
  end
endmodule // analog_partner

//--- tb/tb_top.sv
// Self-checking bench for the supply monitor control block.
// Assumes the package, design, partner model and checker compile first.
`timescale 1ns/100ps
module tb_top;
  localparam logic [3:0] IM = supply_monitor_pkg::IDX_MODE_CTRL;
  localparam logic [3:0] IT = supply_monitor_pkg::IDX_THRESHOLD;
  localparam logic [3:0] IL = supply_monitor_pkg::IDX_WARN_LEVEL;
  localparam logic [3:0] IC = supply_monitor_pkg::IDX_WARN_IRQ_CTRL;
  localparam logic [3:0] IF = supply_monitor_pkg::IDX_WARN_FLAGS;
  localparam logic [3:0] IS = supply_monitor_pkg::IDX_WARN_STATUS;
  logic ref_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, timedUnlock = 1'b0;
  logic sleepDeep = 1'b0, supplyLow = 1'b0, hreadyout, hresp_ff, holdExecution_ff;
  logic warningIrq_ff, monitorRunning, belowWarning, sampleRateSel_ff;
  logic [1:0] htrans = 2'h0, warningLevelSel_ff;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [7:0] fuseWord = 8'h0, sl;
  logic [3:0] runDelay = 4'h1;
  logic [2:0] thresholdCode_ff;
  supply_monitor_pkg::monitor_fuse_config_t fuseConfig;
  supply_monitor_pkg::monitor_mode_t monitorMode_ff;
  int errCount = 0, numChecks = 0;
  // Free-running 50 MHz clock.
  always #10 ref_clk = ~ref_clk;
  supply_monitor_control #(.FAST_CYCLES(8), .SLOW_CYCLES(16)) uut (
    .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp_ff(hresp_ff), .fuseConfig(fuseConfig),
    .timedUnlock(timedUnlock), .sleepDeep(sleepDeep), .monitorRunning(monitorRunning),
    .belowWarning(belowWarning), .monitorMode_ff(monitorMode_ff),
    .sampleRateSel_ff(sampleRateSel_ff), .thresholdCode_ff(thresholdCode_ff),
    .warningLevelSel_ff(warningLevelSel_ff), .holdExecution_ff(holdExecution_ff),
    .warningIrq_ff(warningIrq_ff));
  analog_partner partner (.ref_clk(ref_clk), .rst(rst), .supplyLow(supplyLow),
    .fuseWord(fuseWord), .runDelay(runDelay), .sleepDeep(sleepDeep),
    .fuseConfig(fuseConfig), .monitorRunning(monitorRunning), .belowWarning(belowWarning));
  // ****************************************
  // Bus and check tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      errCount++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    hsel <= 1'b1; hwrite <= 1'b1; htrans <= 2'h2; haddr <= {26'h0, idx, 2'h0};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0; hwdata <= {24'h0, d};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
  endtask
  task automatic rdChk(input logic [3:0] idx, input logic [7:0] exp);
    hsel <= 1'b1; hwrite <= 1'b0; htrans <= 2'h2; haddr <= {26'h0, idx, 2'h0};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    chk(hrdata, {24'h0, exp});
  endtask
  task automatic rstDut();
    rst <= 1'b1;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic tallyAndFinish();
    $display("Checks %0d, mismatches %0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    rstDut();
    for (int i = 8; i < 12; i++) rdChk(4'(i), 8'h00);
    rdChk(4'h3, 8'h00);
    for (int k = 0; k < 4; k++) begin
      fuseWord <= {k[0], k[1:0], 2'(k % 3), k[0] ? 3'h7 : 3'h2};
      runDelay <= 4'(k * 3 + 1);
      rstDut();
      rdChk(IM, {3'h0, fuseWord[7:3]});
      rdChk(IT, {5'h0, fuseWord[2:0]});
      wr(IT, 8'hFF);
      wr(IM, 8'hFF);
      rdChk(IT, {5'h0, fuseWord[2:0]});
      rdChk(IM, {3'h0, 1'b1, fuseWord[6:3]});
      chk(32'(sampleRateSel_ff), 32'h1);
      chk(32'(hresp_ff), 32'h0);
      chk(32'(monitorMode_ff), 32'(k));
      wr(IC, 8'h05);
      supplyLow <= 1'b1;
      repeat (40) @(posedge ref_clk);
      rdChk(IF, {7'h0, k != 0});
      rdChk(IS, {7'h0, k != 0});
      supplyLow <= 1'b0;
      repeat (40) @(posedge ref_clk);
      wr(IF, 8'h01);
      sleepDeep <= 1'b1;
      repeat (4) @(posedge ref_clk);
      chk(32'(monitorMode_ff), 32'(k % 3));
      sleepDeep <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk(32'(holdExecution_ff), 32'(k == 3));
      repeat (16) @(posedge ref_clk);
      chk(32'(holdExecution_ff), 32'h0);
    end
    $display("Test fuse, modes and wake done");
    sl = 8'h0;
    for (int c = 0; c < 4; c++) begin
      timedUnlock <= 1'b1;
      wr(IM, 8'(c));
      timedUnlock <= 1'b0;
      if (c != 3) sl = 8'(c);
      rdChk(IM, {3'h0, 1'b0, fuseWord[6:5], sl[1:0]});
    end
    for (int c = 0; c < 4; c++) begin
      wr(IL, 8'hFC | 8'(c));
      rdChk(IL, 8'(c));
      chk(32'(warningLevelSel_ff), 32'(c));
    end
    $display("Test sleep field and level done");
    for (int t = 0; t < 3; t++) begin
      wr(IC, {5'h0, 2'(t), 1'b1});
      supplyLow <= 1'b1;
      repeat (12) @(posedge ref_clk);
      chk(32'(warningIrq_ff), 32'(t != 1));
      wr(IF, 8'h00);
      rdChk(IF, {7'h0, t != 1});
      wr(IC, {5'h0, 2'(t), 1'b0});
      repeat (2) @(posedge ref_clk);
      chk(32'(warningIrq_ff), 32'h0);
      wr(IF, 8'h01);
      rdChk(IF, 8'h00);
      wr(IC, {5'h0, 2'(t), 1'b1});
      supplyLow <= 1'b0;
      repeat (12) @(posedge ref_clk);
      chk(32'(warningIrq_ff), 32'(t != 0));
      wr(IF, 8'h01);
    end
    $display("Test triggers and interrupt done");
    tallyAndFinish();
  end
  // Cuts a hung run short.
  initial begin
    repeat (20000) @(posedge ref_clk);
    errCount++;
    tallyAndFinish();
  end
endmodule // tb_top
bind supply_monitor_control smc_monitor chk (.*);
